/* File: lbsp_pkg.sv */
// Constants, timing counts and state encoding for the LED boost sequencing block.
// Assumes a single 20 MHz master clock; every count below is in master or switching cycles.
package lbsp_pkg;

	// Master clock and switching clock rates.
	localparam int unsigned MCLK_KHZ = 20000;
	localparam int unsigned SW_KHZ = 1200;
	// Integer division rounds the period down, so the switching rate sits slightly above 1.2 MHz.
	localparam int unsigned SW_DIV = MCLK_KHZ / SW_KHZ;
	localparam int unsigned SW_CNT_W = 5;
	// Maximum duty cycle in percent and the on-time limit in master cycles.
	localparam int unsigned DMAX_PCT = 90;
	localparam int unsigned DMAX_CYC = SW_DIV * DMAX_PCT / 100;

	// Soft-start ramp: step length in microseconds, counted in switching cycles (rounded up).
	localparam int unsigned RAMP_STEPS = 32;
	localparam int unsigned STEP_US = 213;
	localparam int unsigned STEP_SW_CYC = (STEP_US * SW_KHZ + 999) / 1000;
	localparam int unsigned STEP_W = 6;
	localparam int unsigned STEP_TMR_W = 9;

	// Long timers in microseconds and their counts in master cycles.
	localparam int unsigned HALF_LIM_US = 5000;
	localparam int unsigned HALF_LIM_CYC = HALF_LIM_US * MCLK_KHZ / 1000;
	localparam int unsigned OFF_US = 2500;
	localparam int unsigned OFF_CYC = OFF_US * MCLK_KHZ / 1000;
	localparam int unsigned ES_DELAY_US = 100;
	localparam int unsigned ES_DELAY_CYC = ES_DELAY_US * MCLK_KHZ / 1000;
	localparam int unsigned ES_DET_US = 260;
	localparam int unsigned ES_DET_CYC = ES_DET_US * MCLK_KHZ / 1000;
	localparam int unsigned ES_WIN_US = 1000;
	localparam int unsigned ES_WIN_CYC = ES_WIN_US * MCLK_KHZ / 1000;
	localparam int unsigned TMR_W = 17;

	// Open-string persistence in switching cycles.
	localparam int unsigned OPEN_PERSIST = 8;
	localparam int unsigned OPEN_W = 4;

	// Synchronised input vector bit positions.
	localparam int unsigned IN_W = 6;
	localparam int unsigned IN_CTRL = 0;
	localparam int unsigned IN_OVP = 1;
	localparam int unsigned IN_FB_LOW = 2;
	localparam int unsigned IN_UVLO = 3;
	localparam int unsigned IN_THERM = 4;
	localparam int unsigned IN_CMC = 5;

	// Sequencer states, Gray coded along shut, start, run, latched.
	typedef enum logic [1:0] {
		LBSP_SHUT = 2'h0,
		LBSP_START = 2'h1,
		LBSP_RUN = 2'h3,
		LBSP_LATCH = 2'h2
	} lbsp_state_t;

endpackage : lbsp_pkg

/* File: lbsp_core.sv */
// Digital sequencing and protection core of a fixed-frequency LED boost driver.
// Assumes all comparator flags and the control pin are asynchronous to mclk.
// What this block does
// - After enable, raise the reference in 32 equal steps of 204.8 us (256 switching cycles).
// - Hold half current limit for 5 ms after start, then restore full limit.
// - Sample over-voltage and feedback comparators once every switching cycle.
// - Open string needs switch-node over-voltage and feedback below half together.
// - Open condition for 8 consecutive switching cycles turns switch off, shuts down.
// - Open-string shutdown stays latched until the host toggles the control pin.
// - Under-voltage flag forces shutdown with switch off; restart when it clears.
// - Thermal flag forces switch off; resume automatically when it clears.
// - Control pin low longer than 2.5 ms enters shutdown.
// - In shutdown the power switch stays static, no pulses.
// - Drive switch with fixed 1.25 MHz PWM, pulse ended by current comparator.
// - Soft-start step length is counted in switching clock cycles.
// - Dimming mode picked at every enable, PWM unless one-wire pattern seen.
// - In PWM dimming, gate the 200 mV reference at control pin duty.
`timescale 1ns/1ps

module lbsp_core #(
	parameter int unsigned HALF_LIM_CYC = lbsp_pkg::HALF_LIM_CYC,
	parameter int unsigned OFF_CYC = lbsp_pkg::OFF_CYC,
	parameter int unsigned ES_DET_CYC = lbsp_pkg::ES_DET_CYC,
	parameter int unsigned ES_WIN_CYC = lbsp_pkg::ES_WIN_CYC
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic ctrl_pin,
	input wire logic switch_node_ovp,
	input wire logic feedback_sense_low,
	input wire logic uvlo_flag,
	input wire logic thermal_flag,
	input wire logic current_trip,
	output logic sw_gate_q,
	output logic ilim_half_q,
	output logic [lbsp_pkg::STEP_W-1:0] ref_step_q,
	output logic ref_gate_q,
	output logic one_wire_q,
	output logic shutdown_q,
	output logic open_fault_q
);

	localparam logic [lbsp_pkg::TMR_W-1:0] HALF_LIM = lbsp_pkg::TMR_W'(HALF_LIM_CYC);
	localparam logic [lbsp_pkg::TMR_W-1:0] OFF_LIM = lbsp_pkg::TMR_W'(OFF_CYC);
	localparam logic [lbsp_pkg::TMR_W-1:0] DET_LIM = lbsp_pkg::TMR_W'(ES_DET_CYC);
	localparam logic [lbsp_pkg::TMR_W-1:0] WIN_LIM = lbsp_pkg::TMR_W'(ES_WIN_CYC);
	localparam logic [lbsp_pkg::TMR_W-1:0] DELAY_LIM = lbsp_pkg::TMR_W'(lbsp_pkg::ES_DELAY_CYC);
	localparam logic [lbsp_pkg::SW_CNT_W-1:0] SW_LAST = lbsp_pkg::SW_CNT_W'(lbsp_pkg::SW_DIV - 1);
	localparam logic [lbsp_pkg::SW_CNT_W-1:0] ON_LAST =
		lbsp_pkg::SW_CNT_W'(lbsp_pkg::DMAX_CYC - 1);
	localparam logic [lbsp_pkg::STEP_TMR_W-1:0] STEP_LAST =
		lbsp_pkg::STEP_TMR_W'(lbsp_pkg::STEP_SW_CYC - 1);
	localparam logic [lbsp_pkg::STEP_W-1:0] STEP_FULL = lbsp_pkg::STEP_W'(lbsp_pkg::RAMP_STEPS);
	localparam logic [lbsp_pkg::OPEN_W-1:0] OPEN_LAST =
		lbsp_pkg::OPEN_W'(lbsp_pkg::OPEN_PERSIST - 1);

	// Saturating increment shared by all the long timers.
	function automatic logic [lbsp_pkg::TMR_W-1:0] sat_inc(
		input logic [lbsp_pkg::TMR_W-1:0] val,
		input logic [lbsp_pkg::TMR_W-1:0] lim
	);
		if (val >= lim) begin
			sat_inc = lim;
		end else begin
			sat_inc = val + lbsp_pkg::TMR_W'(1);
		end
	endfunction : sat_inc

	logic [lbsp_pkg::IN_W-1:0] raw;
	logic [lbsp_pkg::IN_W-1:0] s1_q;
	logic [lbsp_pkg::IN_W-1:0] s2_q;
	logic [lbsp_pkg::IN_W-1:0] s3_q;
	logic [lbsp_pkg::IN_W-1:0] filt_q;
	logic [lbsp_pkg::IN_W-1:0] filt_d;

	lbsp_pkg::lbsp_state_t state_q;
	lbsp_pkg::lbsp_state_t state_d;
	logic [lbsp_pkg::SW_CNT_W-1:0] sw_cnt_q;
	logic [lbsp_pkg::SW_CNT_W-1:0] sw_cnt_d;
	logic [lbsp_pkg::STEP_TMR_W-1:0] step_tmr_q;
	logic [lbsp_pkg::STEP_TMR_W-1:0] step_tmr_d;
	logic [lbsp_pkg::STEP_W-1:0] step_d;
	logic [lbsp_pkg::TMR_W-1:0] half_tmr_q;
	logic [lbsp_pkg::TMR_W-1:0] half_tmr_d;
	logic [lbsp_pkg::TMR_W-1:0] low_tmr_q;
	logic [lbsp_pkg::TMR_W-1:0] low_tmr_d;
	logic [lbsp_pkg::TMR_W-1:0] win_tmr_q;
	logic [lbsp_pkg::TMR_W-1:0] win_tmr_d;
	logic [lbsp_pkg::TMR_W-1:0] det_tmr_q;
	logic [lbsp_pkg::TMR_W-1:0] det_tmr_d;
	logic [lbsp_pkg::OPEN_W-1:0] open_cnt_q;
	logic [lbsp_pkg::OPEN_W-1:0] open_cnt_d;
	logic gate_d;
	logic ilim_half_d;
	logic ref_gate_d;
	logic one_wire_d;
	logic shutdown_d;
	logic fault_d;
	logic ctrl;
	logic prot;
	logic tick;
	logic active;

	assign raw = {current_trip, thermal_flag, uvlo_flag, feedback_sense_low, switch_node_ovp,
		ctrl_pin};

	// A bit of the filtered vector only moves once the second and third stages agree.
	always_comb begin
		filt_d = (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
	end

	// Three-stage synchronisers and agreement filter for every asynchronous input.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			filt_q <= '0;
		end else begin
			s1_q <= raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			filt_q <= filt_d;
		end
	end

	assign ctrl = filt_q[lbsp_pkg::IN_CTRL];
	assign prot = filt_q[lbsp_pkg::IN_UVLO] | filt_q[lbsp_pkg::IN_THERM];
	assign tick = (sw_cnt_q == SW_LAST);

	// Sequencer next-state logic: enable, soft start, mode detection, PWM and protection.
	always_comb begin
		state_d = state_q;
		step_tmr_d = step_tmr_q;
		step_d = ref_step_q;
		half_tmr_d = half_tmr_q;
		win_tmr_d = win_tmr_q;
		det_tmr_d = det_tmr_q;
		open_cnt_d = open_cnt_q;
		one_wire_d = one_wire_q;
		fault_d = open_fault_q;
		gate_d = 1'h0;
		// The switching divider runs free so the cycle grid never depends on the state.
		sw_cnt_d = tick ? '0 : sw_cnt_q + lbsp_pkg::SW_CNT_W'(1);
		low_tmr_d = ctrl ? '0 : sat_inc(low_tmr_q, OFF_LIM);
		case (state_q)
			lbsp_pkg::LBSP_SHUT: begin
				// Any exit from here starts the ramp and half limit from zero.
				if (ctrl && !prot) begin
					state_d = lbsp_pkg::LBSP_START;
					step_d = '0;
					step_tmr_d = '0;
					half_tmr_d = '0;
					win_tmr_d = '0;
					det_tmr_d = '0;
					one_wire_d = 1'h0;
					open_cnt_d = '0;
					fault_d = 1'h0;
				end
			end
			lbsp_pkg::LBSP_START, lbsp_pkg::LBSP_RUN: begin
				// Reference steps advance on switching ticks only.
				if (tick && (ref_step_q != STEP_FULL)) begin
					if (step_tmr_q == STEP_LAST) begin
						step_tmr_d = '0;
						step_d = ref_step_q + lbsp_pkg::STEP_W'(1);
					end else begin
						step_tmr_d = step_tmr_q + lbsp_pkg::STEP_TMR_W'(1);
					end
				end
				if (step_d == STEP_FULL) begin
					state_d = lbsp_pkg::LBSP_RUN;
				end
				half_tmr_d = sat_inc(half_tmr_q, HALF_LIM);
				// One-wire pattern: a long enough low after the delay, inside the window.
				win_tmr_d = sat_inc(win_tmr_q, WIN_LIM);
				if (!one_wire_q && (win_tmr_q >= DELAY_LIM) && (win_tmr_q < WIN_LIM)) begin
					det_tmr_d = ctrl ? '0 : sat_inc(det_tmr_q, DET_LIM);
					if (det_tmr_q == DET_LIM) begin
						one_wire_d = 1'h1;
					end
				end else begin
					det_tmr_d = '0;
				end
				// The pulse opens at each cycle start and ends on current trip or max duty.
				if (tick) begin
					gate_d = 1'h1;
				end else if (sw_gate_q && !filt_q[lbsp_pkg::IN_CMC] && (sw_cnt_q < ON_LAST)) begin
					gate_d = 1'h1;
				end
				// Open-string check sampled once per switching cycle.
				if (tick) begin
					if (filt_q[lbsp_pkg::IN_OVP] && filt_q[lbsp_pkg::IN_FB_LOW]) begin
						open_cnt_d = open_cnt_q + lbsp_pkg::OPEN_W'(1);
					end else begin
						open_cnt_d = '0;
					end
				end
				if (prot) begin
					state_d = lbsp_pkg::LBSP_SHUT;
					gate_d = 1'h0;
				end else if (low_tmr_q == OFF_LIM) begin
					state_d = lbsp_pkg::LBSP_SHUT;
					gate_d = 1'h0;
				end else if (tick && (open_cnt_q == OPEN_LAST) && filt_q[lbsp_pkg::IN_OVP]
					&& filt_q[lbsp_pkg::IN_FB_LOW]) begin
					state_d = lbsp_pkg::LBSP_LATCH;
					fault_d = 1'h1;
					gate_d = 1'h0;
				end
			end
			lbsp_pkg::LBSP_LATCH: begin
				// Only a low on the control pin releases the latch; a later high restarts.
				if (!ctrl) begin
					state_d = lbsp_pkg::LBSP_SHUT;
				end
			end
			default: begin
				state_d = lbsp_pkg::LBSP_SHUT;
			end
		endcase
		active = (state_d == lbsp_pkg::LBSP_START) || (state_d == lbsp_pkg::LBSP_RUN);
		if (!active) begin
			gate_d = 1'h0;
		end
		shutdown_d = !active;
		ilim_half_d = active && (half_tmr_d < HALF_LIM);
		// In one-wire mode the reference is not chopped by the pin.
		ref_gate_d = active && (one_wire_d || ctrl);
	end

	// Sequencer registers; after reset the switch is off and the device is shut down.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= lbsp_pkg::LBSP_SHUT;
			sw_cnt_q <= '0;
			step_tmr_q <= '0;
			ref_step_q <= '0;
			half_tmr_q <= '0;
			low_tmr_q <= '0;
			win_tmr_q <= '0;
			det_tmr_q <= '0;
			open_cnt_q <= '0;
			sw_gate_q <= 1'h0;
			ilim_half_q <= 1'h0;
			ref_gate_q <= 1'h0;
			one_wire_q <= 1'h0;
			shutdown_q <= 1'h1;
			open_fault_q <= 1'h0;
		end else begin
			state_q <= state_d;
			sw_cnt_q <= sw_cnt_d;
			step_tmr_q <= step_tmr_d;
			ref_step_q <= step_d;
			half_tmr_q <= half_tmr_d;
			low_tmr_q <= low_tmr_d;
			win_tmr_q <= win_tmr_d;
			det_tmr_q <= det_tmr_d;
			open_cnt_q <= open_cnt_d;
			sw_gate_q <= gate_d;
			ilim_half_q <= ilim_half_d;
			ref_gate_q <= ref_gate_d;
			one_wire_q <= one_wire_d;
			shutdown_q <= shutdown_d;
			open_fault_q <= fault_d;
		end
	end

endmodule : lbsp_core

/* File: lbsp_host.sv */
// Host model that drives the single control pin of the boost sequencer.
// Assumes the bench calls its task from one process locked to mclk.
`timescale 1ns/1ps
module lbsp_host (
	input wire logic mclk,
	output logic ctrl_pin
);
	// The pin idles low, as the device's own pull-down would leave it.
	initial ctrl_pin = 1'h0;
	// Change the pin just after an edge, then hold it n cycles; a low held past the
	// shutdown time stops the device, and low then high re-enables it after a latch.
	task automatic level(input logic lvl, input int n);
		@(posedge mclk);
		#5;
		ctrl_pin = lvl;
		repeat (n) @(posedge mclk);
		#5;
	endtask : level
endmodule : lbsp_host

/* File: lbsp_core_properties.sv */
// Concurrent checks on the ports of the sequencing core.
// Assumes one clock, mclk, and the async active-low reset reset_n.
`timescale 1ns/1ps
module lbsp_core_chk (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic switch_node_ovp,
	input wire logic feedback_sense_low,
	input wire logic uvlo_flag,
	input wire logic thermal_flag,
	input wire logic sw_gate_q,
	input wire logic ilim_half_q,
	input wire logic [lbsp_pkg::STEP_W-1:0] ref_step_q,
	input wire logic ref_gate_q,
	input wire logic shutdown_q,
	input wire logic open_fault_q
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// A start is the fall of shutdown; it must find the ramp and limit fresh.
	sequence s_enter;
		$fell(shutdown_q);
	endsequence
	sequence s_fresh;
		ilim_half_q && ref_gate_q && ref_step_q == 6'h0;
	endsequence
	chk_shut_static: assert property (shutdown_q |-> !sw_gate_q)
		else $error("switch pulsed while shut down");
	chk_restart_fresh: assert property (s_enter |-> s_fresh)
		else $error("start without fresh ramp and half limit");
	chk_uvlo_shut: assert property (uvlo_flag [*8] |-> shutdown_q)
		else $error("running under low input");
	chk_therm_shut: assert property (thermal_flag [*8] |-> shutdown_q)
		else $error("running while hot");
	chk_step_unit: assert property (!shutdown_q && $past(shutdown_q) == 1'h0 &&
		$changed(ref_step_q) |-> ref_step_q == $past(ref_step_q) + 6'h1)
		else $error("reference moved by more than one step");
	chk_step_cap: assert property (ref_step_q <= 6'h20)
		else $error("reference step past full scale");
	chk_on_width: assert property ($rose(sw_gate_q) |-> ##[1:14] !sw_gate_q)
		else $error("switch on too long");
	chk_pulse_gap: assert property ($rose(sw_gate_q) |=> (!$rose(sw_gate_q)) [*8])
		else $error("switching faster than the fixed rate");
	// The fault is seen one edge after the final tick, and the input filter keeps a level
	// that left the pins three or four edges before that tick, so both depths are allowed.
	chk_open_cause: assert property ($rose(open_fault_q) |->
		($past(switch_node_ovp, 4) || $past(switch_node_ovp, 5)) &&
		($past(feedback_sense_low, 4) || $past(feedback_sense_low, 5)))
		else $error("open shutdown without both conditions");
endmodule : lbsp_core_chk
bind lbsp_core lbsp_core_chk u_chk (.mclk(mclk), .reset_n(reset_n),
	.switch_node_ovp(switch_node_ovp), .feedback_sense_low(feedback_sense_low),
	.uvlo_flag(uvlo_flag), .thermal_flag(thermal_flag), .sw_gate_q(sw_gate_q),
	.ilim_half_q(ilim_half_q), .ref_step_q(ref_step_q), .ref_gate_q(ref_gate_q),
	.shutdown_q(shutdown_q), .open_fault_q(open_fault_q));

/* File: lbsp_core_tb.sv */
// Self-checking bench for the sequencing core, with a host model on the control pin.
// Assumes the shortened timer parameters set below; the bench drives every comparator flag.
`timescale 1ns/1ps
module lbsp_core_tb;
	logic mclk, reset_n, ctrl_pin, ovp, fbl, uvlo, therm, trip;
	logic sw_gate_q, ilim_half_q, ref_gate_q, one_wire_q, shutdown_q, open_fault_q;
	logic [lbsp_pkg::STEP_W-1:0] ref_step_q;
	int err_count, n_checks, n;
	lbsp_core #(.HALF_LIM_CYC(200), .OFF_CYC(100), .ES_DET_CYC(60), .ES_WIN_CYC(2300)) uut (
		.mclk(mclk), .reset_n(reset_n), .ctrl_pin(ctrl_pin), .switch_node_ovp(ovp),
		.feedback_sense_low(fbl), .uvlo_flag(uvlo), .thermal_flag(therm),
		.current_trip(trip), .sw_gate_q(sw_gate_q), .ilim_half_q(ilim_half_q),
		.ref_step_q(ref_step_q), .ref_gate_q(ref_gate_q), .one_wire_q(one_wire_q),
		.shutdown_q(shutdown_q), .open_fault_q(open_fault_q));
	lbsp_host host (.mclk(mclk), .ctrl_pin(ctrl_pin));
	// Free-running 20 MHz clock.
	initial begin
		mclk = 1'h0;
		forever #25 mclk = ~mclk;
	end
	task automatic cyc(input int k);
		repeat (k) @(posedge mclk);
		#5;
	endtask : cyc
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Waits a bounded time for a start, then expects a fresh ramp and half limit.
	task automatic await_run;
		n = 0;
		while (shutdown_q !== 1'h0 && n < 40) begin
			cyc(1);
			n++;
		end
		chk("shutdown", 16'h0, shutdown_q);
		chk("half_limit", 16'h1, ilim_half_q);
		chk("ref_step", 16'h0, ref_step_q);
	endtask : await_run
	// Counts the cycles with the switch on over four whole switching periods.
	task automatic count_on(output int c);
		c = 0;
		repeat (64) begin
			c += (sw_gate_q === 1'h1);
			cyc(1);
		end
	endtask : count_on
	// Without a trip the pulse runs to the duty limit; a trip ends it after one cycle.
	task automatic t_pulse;
		int c;
		count_on(c);
		chk("on_cycles", 16'h0038, 16'(c));
		trip = 1'h1;
		cyc(8);
		count_on(c);
		chk("trip_cycles", 16'h0004, 16'(c));
		trip = 1'h0;
		cyc(8);
	endtask : t_pulse
	// Half limit length, pulses during it, and the first reference step time.
	task automatic t_start;
		int p;
		p = 0;
		host.level(1'h1, 0);
		await_run();
		n = 0;
		while (ilim_half_q === 1'h1 && n < 300) begin
			p += (sw_gate_q === 1'h1);
			cyc(1);
			n++;
		end
		chk("half_len", 16'h1, n >= 199 && n <= 201);
		chk("pulsing", 16'h1, p > 0);
		while (ref_step_q !== 6'h1 && n < 5000) begin
			cyc(1);
			n++;
		end
		chk("step_time", 16'h1, n >= 4070 && n <= 4112);
	endtask : t_start
	// A short low only chops the reference; a low past the timeout shuts down.
	task automatic t_off;
		host.level(1'h0, 10);
		chk("ref_gate", 16'h0, ref_gate_q);
		host.level(1'h0, 78);
		host.level(1'h1, 10);
		chk("shutdown", 16'h0, shutdown_q);
		host.level(1'h0, 110);
		chk("shutdown", 16'h1, shutdown_q);
	endtask : t_off
	// One-wire pattern selects that mode; the next enable falls back to PWM.
	task automatic t_onewire;
		host.level(1'h1, 0);
		await_run();
		cyc(2010);
		host.level(1'h0, 70);
		host.level(1'h1, 10);
		chk("one_wire", 16'h1, one_wire_q);
		host.level(1'h0, 110);
		host.level(1'h1, 0);
		await_run();
		chk("one_wire", 16'h0, one_wire_q);
	endtask : t_onewire
	// Under-voltage and thermal flags shut down and recover without the host.
	task automatic t_prot;
		for (int k = 0; k < 2; k++) begin
			{uvlo, therm} = k ? 2'h1 : 2'h2;
			cyc(10);
			chk("shutdown", 16'h1, shutdown_q);
			cyc(40);
			{uvlo, therm} = 2'h0;
			await_run();
		end
	endtask : t_prot
	// Open string needs both flags for 8 unbroken ticks, then latches off.
	task automatic t_open;
		int c;
		fbl = 1'h1;
		cyc(200);
		chk("open_fault", 16'h0, open_fault_q);
		ovp = 1'h1;
		cyc(100);
		ovp = 1'h0;
		cyc(40);
		ovp = 1'h1;
		cyc(100);
		chk("open_fault", 16'h0, open_fault_q);
		cyc(60);
		chk("open_fault", 16'h1, open_fault_q);
		{ovp, fbl} = 2'h0;
		cyc(300);
		chk("shutdown", 16'h1, shutdown_q);
		count_on(c);
		chk("latched_pulses", 16'h0, 16'(c));
		host.level(1'h0, 10);
		host.level(1'h1, 0);
		await_run();
		chk("open_fault", 16'h0, open_fault_q);
	endtask : t_open
	task automatic give_verdict;
		if (err_count == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : give_verdict
	// Main sequence after a ten-cycle reset.
	initial begin
		{ovp, fbl, uvlo, therm, trip} = 5'h00;
		reset_n = 1'h0;
		err_count = 0;
		n_checks = 0;
		cyc(10);
		reset_n = 1'h1;
		t_start();
		t_pulse();
		t_off();
		t_onewire();
		t_prot();
		t_open();
		give_verdict();
	end
	// The tests need about 7700 cycles; a hang is cut off well beyond that.
	initial begin
		repeat (30000) @(posedge mclk);
		err_count++;
		give_verdict();
	end
endmodule : lbsp_core_tb
